// file: design/dcl_limiter.sv
// Current demand selection and limit chain
//
// Functional notes
// - Two mode bits pick one of four modes
// - Speed mode passes speed loop output through
// - Demand clamped by taper and bridge limits
// - Final limited demand readable by software
// - Override limit is min of taper, limit two when selected
// - Taper limit symmetric, 0 to 1000, default 1000
// - Positive demand capped by bridge one limit
// - Negative demand capped by bridge two limit
// - Second limit applies to both bridges
// - Select bit picks alternate limit, resets zero
// - Signed torque reference, default zero
// - Offset added only when offset select set
// - Basic torque mode feeds torque reference
// - Override mode clamps speed output by polarity
// - Motoring quadrants limit speed to demand
// - Regenerating quadrants disable torque below demand
// - Torque reference acts as adjustable limit
// - Second limit applied after delay from run
// - Auto change-over sets select after interval
// - Coiler opposite sense selects zero speed ref
`timescale 1ns/10ps
module dcl_limiter
  import dcl_pkg::*;
#(
  parameter int SEC_CYC = DCL_SEC_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Drive signals
  input wire logic signed [10:0] speed_loop_out,
  input wire logic signed [10:0] speed_error,
  input wire logic signed [10:0] speed_fb,
  input wire logic signed [10:0] final_speed_demand,
  input wire logic [9:0] taper_result,
  input wire logic run,
  // Coiler speed reference choice and demand out
  output logic coiler_zero_ref,
  output logic signed [10:0] current_demand_out
);
  logic [9:0] taper_reg;
  logic [9:0] br1_reg;
  logic [9:0] br2_reg;
  logic [9:0] lim2_reg;
  logic signed [10:0] torq_reg;
  logic signed [10:0] offs_reg;
  logic altsel_reg;
  logic offsel_reg;
  logic [1:0] modebits_reg;
  logic auto_reg;
  logic [7:0] timer_reg;
  logic signed [10:0] pre_reg;
  logic signed [10:0] final_reg;
  logic [9:0] ovr_reg;
  logic coiler_reg;
  dcl_mode_t mode;
  logic signed [10:0] sel_next;
  logic signed [11:0] sum_next;
  logic [9:0] ovr_next;
  logic [9:0] pos_lim;
  logic [9:0] neg_lim;
  logic signed [10:0] pre_next;
  logic signed [10:0] final_next;
  logic expired;
  logic wr_ctrl;

  dcl_sec_timer #(
    .SEC_CYC(SEC_CYC)
  ) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(run),
    .delay_s(timer_reg),
    .expired(expired)
  );

  // Mode decode
  always_comb begin
    case (modebits_reg)
      2'b00: mode = DCL_MODE_SPEED;
      2'b01: mode = DCL_MODE_TORQUE;
      2'b10: mode = DCL_MODE_OVERRIDE;
      2'b11: mode = DCL_MODE_COILER;
      default: mode = DCL_MODE_SPEED;
    endcase
  end

  // Demand source selection
  always_comb begin
    sel_next = speed_loop_out;
    case (mode)
      DCL_MODE_SPEED: sel_next = speed_loop_out;
      DCL_MODE_TORQUE: sel_next = torq_reg;
      DCL_MODE_OVERRIDE: begin
        // Speed output clamped between zero and torque reference
        if (torq_reg >= 0) begin
          if (speed_error < 0 || speed_loop_out < 0) begin
            sel_next = 11'sh000;
          end else if (speed_loop_out > torq_reg) begin
            sel_next = torq_reg;
          end else begin
            sel_next = speed_loop_out;
          end
        end else begin
          if (speed_error > 0 || speed_loop_out > 0) begin
            sel_next = 11'sh000;
          end else if (speed_loop_out < torq_reg) begin
            sel_next = torq_reg;
          end else begin
            sel_next = speed_loop_out;
          end
        end
      end
      // Speed loop has already seen the zero reference
      DCL_MODE_COILER: sel_next = speed_loop_out;
      default: sel_next = speed_loop_out;
    endcase
  end

  // Offset trim, widened so it cannot wrap
  assign sum_next = offsel_reg ? (12'(sel_next) + 12'(offs_reg)) : 12'(sel_next);

  // Override limit: taper result capped by taper limit, or limit two if lower and selected
  always_comb begin
    ovr_next = taper_result;
    if (ovr_next > taper_reg) begin
      ovr_next = taper_reg;
    end
    if (altsel_reg && lim2_reg < ovr_next) begin
      ovr_next = lim2_reg;
    end
  end

  assign pos_lim = (br1_reg < ovr_next) ? br1_reg : ovr_next;
  assign neg_lim = (br2_reg < ovr_next) ? br2_reg : ovr_next;

  dcl_sat u_pre (
    .din(sum_next),
    .pos_lim(10'h3ff),
    .neg_lim(10'h3ff),
    .dout(pre_next)
  );

  dcl_sat u_final (
    .din(sum_next),
    .pos_lim(pos_lim),
    .neg_lim(neg_lim),
    .dout(final_next)
  );

  // Chain registered every cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pre_reg <= 11'sh000;
      final_reg <= 11'sh000;
      ovr_reg <= 10'h000;
      coiler_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      final_reg <= final_next;
      ovr_reg <= ovr_next;
      coiler_reg <= (mode == DCL_MODE_COILER) &&
        ((torq_reg < 0 && speed_fb > 0) || (torq_reg > 0 && speed_fb < 0));
    end
  end
  assign current_demand_out = final_reg;
  assign coiler_zero_ref = coiler_reg;

  assign wr_ctrl = reg_wr && reg_addr == DCL_A_CTRL;

  // Settings
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      taper_reg <= DCL_LIM_RST;
      br1_reg <= DCL_LIM_RST;
      br2_reg <= DCL_LIM_RST;
      lim2_reg <= DCL_LIM2_RST;
      torq_reg <= DCL_ZERO_RST;
      offs_reg <= DCL_ZERO_RST;
      timer_reg <= DCL_TIMER_RST;
    end else if (reg_wr) begin
      // Out of range limit magnitudes saturate at full scale
      case (reg_addr)
        DCL_A_TAPER: taper_reg <= (reg_wdata > 16'h03e8) ? DCL_LIM_RST : reg_wdata[9:0];
        DCL_A_BR1: br1_reg <= (reg_wdata > 16'h03e8) ? DCL_LIM_RST : reg_wdata[9:0];
        DCL_A_BR2: br2_reg <= (reg_wdata > 16'h03e8) ? DCL_LIM_RST : reg_wdata[9:0];
        DCL_A_LIM2: lim2_reg <= (reg_wdata > 16'h03e8) ? DCL_LIM_RST : reg_wdata[9:0];
        DCL_A_TORQ: torq_reg <= reg_wdata[10:0];
        DCL_A_OFFS: offs_reg <= reg_wdata[10:0];
        DCL_A_TIMER: timer_reg <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Control bits; automatic set wins over a software clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      altsel_reg <= 1'b0;
      offsel_reg <= 1'b0;
      modebits_reg <= 2'b00;
      auto_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        offsel_reg <= reg_wdata[DCL_B_OFFSEL];
        modebits_reg <= {reg_wdata[DCL_B_MODE1], reg_wdata[DCL_B_MODE0]};
        auto_reg <= reg_wdata[DCL_B_AUTO];
      end
      if (auto_reg && expired) begin
        altsel_reg <= 1'b1;
      end else if (wr_ctrl) begin
        altsel_reg <= reg_wdata[DCL_B_ALTSEL];
      end
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        DCL_A_PRE: reg_rdata <= 16'($signed(pre_reg));
        DCL_A_FINAL: reg_rdata <= 16'($signed(final_reg));
        DCL_A_OVR: reg_rdata <= {6'h00, ovr_reg};
        DCL_A_TAPER: reg_rdata <= {6'h00, taper_reg};
        DCL_A_BR1: reg_rdata <= {6'h00, br1_reg};
        DCL_A_BR2: reg_rdata <= {6'h00, br2_reg};
        DCL_A_LIM2: reg_rdata <= {6'h00, lim2_reg};
        DCL_A_TORQ: reg_rdata <= 16'($signed(torq_reg));
        DCL_A_OFFS: reg_rdata <= 16'($signed(offs_reg));
        DCL_A_CTRL: reg_rdata <= {11'h000, auto_reg, modebits_reg, offsel_reg, altsel_reg};
        DCL_A_TIMER: reg_rdata <= {8'h00, timer_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Checks
  final_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ($signed(final_reg) <= $signed({1'b0, ovr_reg}) && $signed(final_reg) >= -$signed({1'b0, ovr_reg})))
    else $error("final demand exceeds override limit");
  br1_cap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $signed(final_reg) <= $signed({1'b0, $past(br1_reg)}))
    else $error("positive demand above bridge one limit");
  br2_cap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $signed(final_reg) >= -$signed({1'b0, $past(br2_reg)}))
    else $error("negative demand below bridge two limit");
  speed_pass_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_SPEED && !offsel_reg && speed_loop_out >= 0 && speed_loop_out <= $signed({1'b0, pos_lim}))
    |=> final_reg == $past(speed_loop_out))
    else $error("speed mode demand not passed");
  torque_pass_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_TORQUE && !offsel_reg && torq_reg >= 0 && torq_reg <= $signed({1'b0, pos_lim}))
    |=> final_reg == $past(torq_reg))
    else $error("torque mode demand not passed");
  ovr_min_a: assert property (@(posedge mclk) disable iff (!rst_b)
    altsel_reg |=> ovr_reg <= $past(lim2_reg))
    else $error("override limit above second limit");
  auto_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (auto_reg && expired) |=> altsel_reg)
    else $error("automatic change-over missed");
  override_clamp_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_OVERRIDE && torq_reg >= 0)
    |=> 12'(pre_reg) <= 12'($past(torq_reg)) + ($past(offsel_reg) ? 12'($past(offs_reg)) : 12'sh000))
    else $error("override clamp exceeded");

  // Trim sum built apart from the datapath, so the checks do not echo it
  logic signed [11:0] chk_tsum;
  assign chk_tsum = 12'(torq_reg) + 12'(offs_reg);

  // Reset values; checked with reset active, so no disable here
  ctrl_reset_a: assert property (@(posedge mclk)
    !rst_b |=> (!altsel_reg && !offsel_reg && modebits_reg == 2'b00 && !auto_reg))
    else $error("control bits not cleared by reset");
  lim_reset_a: assert property (@(posedge mclk)
    !rst_b |=> (taper_reg == DCL_LIM_RST && br1_reg == DCL_LIM_RST && br2_reg == DCL_LIM_RST))
    else $error("limit settings not reset to full scale");
  ref_reset_a: assert property (@(posedge mclk)
    !rst_b |=> (torq_reg == 11'sh000 && offs_reg == 11'sh000))
    else $error("torque reference or offset not reset to zero");

  mode_decode_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ((modebits_reg == 2'b01) == (mode == DCL_MODE_TORQUE)) && ((modebits_reg == 2'b10) == (mode == DCL_MODE_OVERRIDE))
    && ((modebits_reg == 2'b11) == (mode == DCL_MODE_COILER)))
    else $error("mode bits decoded wrongly");

  // Trim applied only when selected, and pre-limit sum saturates
  speed_trim_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_SPEED && !offsel_reg) |=> pre_reg == $past(speed_loop_out))
    else $error("pre-limit demand differs from speed output");
  torque_trim_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_TORQUE && offsel_reg && chk_tsum >= -12'sd1023 && chk_tsum <= 12'sd1023)
    |=> pre_reg == 11'($past(chk_tsum)))
    else $error("offset not added to torque demand");
  pre_sat_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sum_next > 12'sd1023 |=> pre_reg == 11'sd1023) and (sum_next < -12'sd1023 |=> pre_reg == -11'sd1023))
    else $error("pre-limit demand wrapped");

  // Override mode polarity handling
  override_neg_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_OVERRIDE && torq_reg < 0 && !offsel_reg)
    |=> (pre_reg >= $past(torq_reg) && pre_reg <= 11'sh000))
    else $error("negative override clamp exceeded");
  quadrant_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_OVERRIDE && !offsel_reg
    && ((torq_reg >= 0 && speed_error < 0) || (torq_reg < 0 && speed_error > 0)))
    |=> pre_reg == 11'sh000)
    else $error("override demand not zeroed");

  // Override limit sources
  taper_cap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!altsel_reg && taper_result <= taper_reg) |=> ovr_reg == $past(taper_result))
    else $error("override limit not taper result");
  lim2_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!altsel_reg && taper_result >= taper_reg) |=> ovr_reg == $past(taper_reg))
    else $error("override limit not taper setting");
  taper_clip_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == DCL_A_TAPER && reg_wdata > 16'h03e8) |=> taper_reg == DCL_LIM_RST)
    else $error("taper limit write not saturated");

  // Coiler zero reference
  coiler_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == DCL_MODE_COILER && torq_reg > 0 && speed_fb < 0) |=> coiler_zero_ref)
    else $error("coiler zero reference missed");
  coiler_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode != DCL_MODE_COILER) |=> !coiler_zero_ref)
    else $error("coiler zero reference outside coiler mode");

  // Read port timing
  read_final_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr == DCL_A_FINAL) |=> reg_rdata == 16'($signed($past(final_reg))))
    else $error("final demand read wrong");
  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero without strobe");

  // Change-over steps: armed, select raised, then limit two applied
  sequence alt_armed_s;
    auto_reg && expired;
  endsequence
  sequence alt_applied_s;
    altsel_reg ##1 (ovr_reg <= $past(lim2_reg));
  endsequence
  alt_apply_a: assert property (@(posedge mclk) disable iff (!rst_b)
    alt_armed_s |=> alt_applied_s)
    else $error("second limit not applied after change-over");
  timer_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(run) |-> (expired == (timer_reg == 8'h00)))
    else $error("change-over delay not restarted at run");
endmodule // dcl_limiter

// file: design/dcl_pkg.sv
// Package of constants for the current demand limiter
package dcl_pkg;
  typedef enum logic [1:0] {
    DCL_MODE_SPEED,
    DCL_MODE_TORQUE,
    DCL_MODE_OVERRIDE,
    DCL_MODE_COILER
  } dcl_mode_t;
  localparam int DCL_AW = 5;
  localparam int DCL_DW = 16;
  localparam logic signed [10:0] DCL_FULL = 11'sh3e8;
  localparam logic [9:0] DCL_LIM_RST = 10'h3e8;
  localparam logic [9:0] DCL_LIM2_RST = 10'h3e8;
  localparam logic [10:0] DCL_ZERO_RST = 11'h000;
  // Register addresses
  localparam logic [4:0] DCL_A_PRE = 5'h01;
  localparam logic [4:0] DCL_A_FINAL = 5'h02;
  localparam logic [4:0] DCL_A_OVR = 5'h03;
  localparam logic [4:0] DCL_A_TAPER = 5'h04;
  localparam logic [4:0] DCL_A_BR1 = 5'h05;
  localparam logic [4:0] DCL_A_BR2 = 5'h06;
  localparam logic [4:0] DCL_A_LIM2 = 5'h07;
  localparam logic [4:0] DCL_A_TORQ = 5'h08;
  localparam logic [4:0] DCL_A_OFFS = 5'h09;
  localparam logic [4:0] DCL_A_CTRL = 5'h0a;
  localparam logic [4:0] DCL_A_TIMER = 5'h13;
  localparam logic [4:0] DCL_A_TAPRES = 5'h14;
  // Control register bit positions
  localparam int DCL_B_ALTSEL = 0;
  localparam int DCL_B_OFFSEL = 1;
  localparam int DCL_B_MODE0 = 2;
  localparam int DCL_B_MODE1 = 3;
  localparam int DCL_B_AUTO = 4;
  // Timer
  localparam int DCL_CLK_HZ = 100_000_000;
  localparam int DCL_SEC_S = 1;
  localparam int DCL_SEC_CYC = DCL_CLK_HZ * DCL_SEC_S;
  localparam logic [7:0] DCL_TIMER_RST = 8'h00;
endpackage

// file: design/dcl_sat.sv
// Signed saturating clamp to an asymmetric window
`timescale 1ns/10ps
module dcl_sat
  import dcl_pkg::*;
(
  // Value and window
  input wire logic signed [11:0] din,
  input wire logic [9:0] pos_lim,
  input wire logic [9:0] neg_lim,
  // Result
  output logic signed [10:0] dout
);
  logic signed [11:0] p;
  logic signed [11:0] n;
  assign p = $signed({2'b00, pos_lim});
  assign n = -$signed({2'b00, neg_lim});
  always_comb begin
    if (din > p) begin
      dout = p[10:0];
    end else if (din < n) begin
      dout = n[10:0];
    end else begin
      dout = din[10:0];
    end
  end
endmodule // dcl_sat

// file: design/dcl_sec_timer.sv
// One-second tick and run delay counter
`timescale 1ns/10ps
module dcl_sec_timer
  import dcl_pkg::*;
#(
  parameter int SEC_CYC = DCL_SEC_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic [7:0] delay_s,
  // Result
  output logic expired
);
  logic [31:0] div_reg;
  logic [7:0] sec_reg;
  logic tick;
  assign tick = (div_reg == 32'(SEC_CYC - 1));
  always_ff @(posedge mclk) begin
    if (!rst_b || !run || tick) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b || !run) begin
      sec_reg <= 8'h00;
    end else if (tick && sec_reg != 8'hff) begin
      sec_reg <= sec_reg + 8'h01;
    end
  end
  // Held while running once delay reached
  assign expired = run && (sec_reg >= delay_s);
endmodule // dcl_sec_timer

// file: bench/dcl_partner.sv
// Speed loop and current loop stand-in for the limiter bench
`timescale 1ns/10ps
module dcl_partner (
  // Clock
  input wire logic mclk,
  // Values asked for by the bench
  input wire logic signed [10:0] slo_in,
  input wire logic signed [10:0] err_in,
  input wire logic signed [10:0] fb_in,
  // Speed loop side
  output logic signed [10:0] speed_loop_out,
  output logic signed [10:0] speed_error,
  output logic signed [10:0] speed_fb,
  output logic signed [10:0] final_speed_demand,
  // Current loop side
  input wire logic signed [10:0] demand_in,
  output logic signed [10:0] demand_seen
);
  // Zero final speed demand for regenerating use
  assign final_speed_demand = 11'sh000;
  // Outputs move only on an edge, never between, as a clocked speed loop would
  always_ff @(posedge mclk) begin
    speed_loop_out <= slo_in;
    speed_error <= err_in;
    speed_fb <= fb_in;
    demand_seen <= demand_in;
  end
endmodule // dcl_partner

// file: bench/dcl_limiter_test.sv
// Self-checking bench for the current demand limiter
`timescale 1ns/10ps
module dcl_limiter_test;
  import dcl_pkg::*;
  localparam int SC = 10;
  logic mclk, rst_b, reg_wr, reg_rd, run, coiler_zero_ref;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [9:0] taper_result;
  logic signed [10:0] slo, err, fb, speed_loop_out, speed_error, speed_fb;
  logic signed [10:0] final_speed_demand, current_demand_out;
  logic [31:0] seed;
  int fail_count, tests_run;
  int tap, b1, b2, l2, tq, of, alt, ofs, md, tr, ov, pre, ex, vs, ve, vf;
  logic [4:0] ra[6] = '{DCL_A_TAPER, DCL_A_BR2, DCL_A_TORQ, DCL_A_OFFS, DCL_A_CTRL, 5'h1f};
  logic [15:0] rv[6] = '{16'h03e8, 16'h03e8, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  dcl_limiter #(.SEC_CYC(SC)) dcl_limiter_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .speed_loop_out(speed_loop_out), .speed_error(speed_error), .speed_fb(speed_fb),
    .final_speed_demand(final_speed_demand), .taper_result(taper_result), .run(run),
    .coiler_zero_ref(coiler_zero_ref), .current_demand_out(current_demand_out));
  dcl_partner dcl_partner_i (.mclk(mclk), .slo_in(slo), .err_in(err), .fb_in(fb),
    .speed_loop_out(speed_loop_out), .speed_error(speed_error), .speed_fb(speed_fb),
    .final_speed_demand(final_speed_demand), .demand_in(current_demand_out), .demand_seen());

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic int rn(input int n);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed % n);
  endfunction
  function automatic int lim(input int v, input int lo, input int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  function automatic int mn(input int a, input int b);
    return a < b ? a : b;
  endfunction
  // Limits favour the 0 and 1000 ends, where off-by-one slips show
  function automatic int rl();
    return rn(4) == 0 ? 1000 * rn(2) : rn(1001);
  endfunction
  function automatic int sel_dem();
    if (md == 1) begin
      return tq;
    end
    if (md == 2) begin
      return tq >= 0 ? (ve < 0 ? 0 : lim(vs, 0, tq)) : (ve > 0 ? 0 : lim(vs, tq, 0));
    end
    return vs;
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input int v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= 16'(v);
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic trial();
    wr(DCL_A_TAPER, tap);
    wr(DCL_A_BR1, b1);
    wr(DCL_A_BR2, b2);
    wr(DCL_A_LIM2, l2);
    wr(DCL_A_TORQ, tq);
    wr(DCL_A_OFFS, of);
    wr(DCL_A_CTRL, alt | (ofs << 1) | (md << 2));
    @(posedge mclk);
    slo <= 11'(vs);
    err <= 11'(ve);
    fb <= 11'(vf);
    taper_result <= 10'(tr);
    // Partner adds one register stage ahead of the limiter
    repeat (2) @(posedge mclk);
    #1;
    ov = mn(tr, tap);
    if (alt == 1) begin
      ov = mn(ov, l2);
    end
    pre = lim(sel_dem() + (ofs == 1 ? of : 0), -1023, 1023);
    ex = lim(pre, -mn(b2, ov), mn(b1, ov));
    chk("demand_out", 16'(ex), 16'(current_demand_out));
    chk("coiler_zero_ref", 16'(md == 3 && vf != 0 && tq != 0 && ((vf < 0) != (tq < 0))),
      16'(coiler_zero_ref));
    rd(DCL_A_OVR, d);
    chk("override_limit", 16'(ov), d);
    rd(DCL_A_PRE, d);
    chk("pre_limit", 16'(pre), d);
    rd(DCL_A_FINAL, d);
    chk("final_demand", 16'(ex), d);
  endtask

  initial begin
    {rst_b, reg_wr, reg_rd, run, reg_addr, reg_wdata, taper_result} = '0;
    {slo, err, fb} = '0;
    seed = 32'h95af7810;
    fail_count = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk("reset_value", rv[i], d);
    end
    // Out of range limit setting saturates
    wr(DCL_A_TAPER, 16'h07ff);
    rd(DCL_A_TAPER, d);
    chk("taper_clip", 16'h03e8, d);
    // Timed change-over after run
    wr(DCL_A_TIMER, 2);
    wr(DCL_A_CTRL, 16'h0010);
    @(posedge mclk);
    run <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(DCL_A_CTRL, d);
    chk("alt_early", 16'h0010, d);
    for (int k = 0; k < 40 && d[0] !== 1'b1; k++) begin
      rd(DCL_A_CTRL, d);
    end
    chk("alt_auto", 16'h0011, d);
    run <= 1'b0;
    // Reset as run drops clears the automatically set select
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(DCL_A_CTRL, d);
    chk("alt_reset", 16'h0000, d);
    rd(DCL_A_TIMER, d);
    chk("timer_reset", 16'h0000, d);
    wr(DCL_A_CTRL, 0);
    for (int i = 0; i < 48; i++) begin
      md = i % 4;
      tap = rl();
      b1 = rl();
      b2 = rl();
      l2 = rl();
      tr = rl();
      tq = rn(2001) - 1000;
      of = rn(2001) - 1000;
      vs = rn(2001) - 1000;
      ve = rn(2001) - 1000;
      vf = rn(2001) - 1000;
      alt = rn(2);
      ofs = rn(2);
      // Offset pushes the sum past the 11-bit range
      if (i == 0) begin
        vs = 1000;
        of = 1000;
        ofs = 1;
      end
      trial();
    end
    wrap_up();
  end
endmodule // dcl_limiter_test
